// *** design/sadc_map.svh ***
// offsets, field positions, reset values and timing counts of the
// converter sequencer; definitions only, included by sadc_top
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
// register byte offsets
`define SADC_OFF_MODE 8'h00
`define SADC_OFF_CHAN 8'h04
`define SADC_OFF_PIN 8'h08
`define SADC_OFF_RESULT 8'h0c
`define SADC_OFF_RESULT_HI 8'h10
`define SADC_OFF_STATUS 8'h14
// converter_mode_reg fields
`define SADC_MODE_ENABLE_BIT 0
`define SADC_MODE_TIME_LSB 1
`define SADC_MODE_TIME_MSB 5
`define SADC_MODE_RUN_BIT 7
// channel_select_reg and pin_analog_config fields
`define SADC_CHAN_MSB 2
`define SADC_PIN_MSB 3
// reset values
`define SADC_MODE_RESET 8'h00
`define SADC_CHAN_RESET 3'h0
`define SADC_PIN_RESET 4'h0
`define SADC_RESULT_RESET 16'h0000
`define SADC_RESULT_HI_RESET 8'h00
// search
`define SADC_FIRST_TRIAL 10'h200
`define SADC_RESULT_PAD 6'h00
// timing
`define SADC_CLOCK_NS 40
`define SADC_TRIAL_MIN 6'h02
`define SADC_SAMPLE_TRIALS 2'h2
`define SADC_SETTLE_NS 1000
`define SADC_SETTLE_CYCLES \
  ((`SADC_SETTLE_NS + `SADC_CLOCK_NS - 1) / `SADC_CLOCK_NS)
// bus answers
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2
`endif

// *** design/sadc_pkg.sv ***
// types of the converter sequencer, imported by sadc_top only
// assumes sadc_map.svh supplies all numeric constants
package sadc_pkg;
  typedef enum logic [1:0]
  {
    st_idle = 2'b00,
    st_sample = 2'b01,
    st_convert = 2'b11
  } sadc_state_type;

  typedef enum logic [2:0]
  {
    sel_mode,
    sel_chan,
    sel_pin,
    sel_result,
    sel_result_hi,
    sel_status,
    sel_none
  } sadc_sel_type;
endpackage

// *** design/sadc_trial_timer.sv ***
// trial period timer: one tick per trial period
// assumes i_period of at least two clocks
`timescale 1ns/100ps
module sadc_trial_timer
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // control
  input wire logic i_restart,
  input wire logic [5:0] i_period,
  // tick
  output logic o_tick
);
  logic [5:0] count_reg;

  assign o_tick = (count_reg == i_period - 6'h01);

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      count_reg <= 6'h00;
    else if (i_restart || o_tick)
      count_reg <= 6'h00;
    else
      count_reg <= count_reg + 6'h01;
  end
endmodule

// *** design/sadc_approx_search.sv ***
// approximation register: binary search from the top bit down
// assumes i_comp_ge is high when the held input is at or above the tap
`timescale 1ns/100ps
`include "sadc_map.svh"
module sadc_approx_search
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // control
  input wire logic i_start,
  input wire logic i_step,
  input wire logic i_comp_ge,
  // state
  output logic [9:0] o_code,
  output logic [9:0] o_decided,
  output logic o_last
);
  logic [9:0] trial_bit_reg;

  assign o_last = trial_bit_reg[0];
  // code with the current trial bit resolved
  assign o_decided = i_comp_ge ? o_code : (o_code & ~trial_bit_reg);

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_code <= 10'h000;
      trial_bit_reg <= 10'h000;
    end
    else if (i_start)
    begin
      o_code <= `SADC_FIRST_TRIAL;
      trial_bit_reg <= `SADC_FIRST_TRIAL;
    end
    else if (i_step)
    begin
      o_code <= o_decided | (trial_bit_reg >> 1);
      trial_bit_reg <= trial_bit_reg >> 1;
    end
  end
endmodule

// *** design/sadc_top.sv ***
// converter sequencer: axi4-lite registers, sampling, bit search, results
// assumes a synchronous comparator output and one 25 MHz clock
`timescale 1ns/100ps
`include "sadc_map.svh"
module sadc_top
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // axi4-lite write address and data
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  // axi4-lite write response
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // analog side
  input wire logic i_comp_ge,
  output logic o_comparator_enable,
  output logic o_sampling,
  output logic o_hold,
  output logic [2:0] o_channel,
  output logic [9:0] o_tap_code,
  output logic [3:0] o_pin_analog_config,
  // completion
  output logic o_conversion_done_irq
);
  import sadc_pkg::*;

  function automatic sadc_sel_type decode(input logic [7:0] addr);
    logic [7:0] word;
    word = {addr[7:2], 2'b00};
    if (word == `SADC_OFF_MODE)
      decode = sel_mode;
    else if (word == `SADC_OFF_CHAN)
      decode = sel_chan;
    else if (word == `SADC_OFF_PIN)
      decode = sel_pin;
    else if (word == `SADC_OFF_RESULT)
      decode = sel_result;
    else if (word == `SADC_OFF_RESULT_HI)
      decode = sel_result_hi;
    else if (word == `SADC_OFF_STATUS)
      decode = sel_status;
    else
      decode = sel_none;
  endfunction

  // bus state
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_strb0_reg;
  // block state
  logic [7:0] converter_mode_reg;
  logic [2:0] channel_select_reg;
  logic [3:0] pin_analog_cfg_reg;
  logic [15:0] result_word_reg;
  logic [7:0] result_high_byte_reg;
  logic [4:0] settle_reg;
  logic [1:0] sample_cnt_reg;
  sadc_state_type state_reg;
  sadc_state_type state_next;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic aw_full_next;
  logic w_full_next;
  logic bvalid_next;
  logic rvalid_next;
  sadc_sel_type wr_sel;
  logic mode_wr;
  logic chan_wr;
  logic pin_wr;
  logic cfg_wr;
  logic run_now;
  logic start_conv;
  logic tick;
  logic sample_last;
  logic approx_start;
  logic approx_step;
  logic approx_last;
  logic [9:0] approx_code;
  logic [9:0] approx_decided;
  logic done;
  logic load;
  logic settled;
  logic [5:0] trial_period;
  logic [31:0] read_value;

  // write channel handshakes; address and data taken in either order
  assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
  assign w_take = i_s_axi_wvalid && o_s_axi_wready;
  assign do_write = aw_full_reg && w_full_reg;
  assign aw_full_next = (aw_full_reg || aw_take) && !do_write;
  assign w_full_next = (w_full_reg || w_take) && !do_write;
  assign bvalid_next = do_write || (o_s_axi_bvalid && !i_s_axi_bready);
  assign ar_take = i_s_axi_arvalid && o_s_axi_arready;
  assign rvalid_next = ar_take || (o_s_axi_rvalid && !i_s_axi_rready);

  assign wr_sel = decode(aw_addr_reg);
  assign mode_wr = do_write && w_strb0_reg && (wr_sel == sel_mode);
  assign chan_wr = do_write && w_strb0_reg && (wr_sel == sel_chan);
  assign pin_wr = do_write && w_strb0_reg && (wr_sel == sel_pin);
  assign cfg_wr = mode_wr || chan_wr || pin_wr;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `SADC_RESP_OKAY;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_take)
        aw_addr_reg <= i_s_axi_awaddr;
      if (w_take)
      begin
        w_data_reg <= i_s_axi_wdata[7:0];
        w_strb0_reg <= i_s_axi_wstrb[0];
      end
      o_s_axi_awready <= !aw_full_next && !bvalid_next;
      o_s_axi_wready <= !w_full_next && !bvalid_next;
      o_s_axi_bvalid <= bvalid_next;
      if (do_write)
        o_s_axi_bresp <= (wr_sel == sel_none) ? `SADC_RESP_SLVERR
                                              : `SADC_RESP_OKAY;
    end
  end

  // configuration registers
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      converter_mode_reg <= `SADC_MODE_RESET;
      channel_select_reg <= `SADC_CHAN_RESET;
      pin_analog_cfg_reg <= `SADC_PIN_RESET;
    end
    else
    begin
      if (mode_wr)
        converter_mode_reg <= w_data_reg & 8'hbf;
      if (chan_wr)
        channel_select_reg <= w_data_reg[`SADC_CHAN_MSB:0];
      if (pin_wr)
        pin_analog_cfg_reg <= w_data_reg[`SADC_PIN_MSB:0];
    end
  end

  // comparator settle indication after enable
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      settle_reg <= 5'h00;
    else if (!converter_mode_reg[`SADC_MODE_ENABLE_BIT])
      settle_reg <= 5'h00;
    else if (!settled)
      settle_reg <= settle_reg + 5'h01;
  end
  assign settled = (settle_reg == 5'(`SADC_SETTLE_CYCLES));

  // read path; value sampled at acceptance, before any same-edge load
  always_comb
  begin
    read_value = 32'h0000_0000;
    case (decode(i_s_axi_araddr))
      sel_mode: read_value[7:0] = converter_mode_reg;
      sel_chan: read_value[2:0] = channel_select_reg;
      sel_pin: read_value[3:0] = pin_analog_cfg_reg;
      sel_result: read_value[15:0] = result_word_reg;
      sel_result_hi: read_value[7:0] = result_high_byte_reg;
      sel_status: read_value[3:0] = {settled, o_hold, state_reg};
      default: read_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `SADC_RESP_OKAY;
    end
    else
    begin
      o_s_axi_arready <= !rvalid_next;
      o_s_axi_rvalid <= rvalid_next;
      if (ar_take)
      begin
        o_s_axi_rdata <= read_value;
        o_s_axi_rresp <= (decode(i_s_axi_araddr) == sel_none)
                         ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
      end
    end
  end

  // sequencer
  assign run_now = mode_wr ? w_data_reg[`SADC_MODE_RUN_BIT]
                           : converter_mode_reg[`SADC_MODE_RUN_BIT];
  assign start_conv = run_now && ((state_reg == st_idle) || chan_wr);
  assign trial_period = {1'b0,
    converter_mode_reg[`SADC_MODE_TIME_MSB:`SADC_MODE_TIME_LSB]}
    + `SADC_TRIAL_MIN;
  assign sample_last = (sample_cnt_reg == `SADC_SAMPLE_TRIALS - 2'h1);

  always_comb
  begin
    state_next = state_reg;
    if (!run_now)
      state_next = st_idle;
    else if (start_conv)
      state_next = st_sample;
    else if (tick && (state_reg == st_sample) && sample_last)
      state_next = st_convert;
    else if (tick && (state_reg == st_convert) && approx_last)
      state_next = st_sample;
  end

  assign approx_start = (state_reg == st_sample) &&
                        (state_next == st_convert);
  assign approx_step = (state_reg == st_convert) &&
                       (state_next == st_convert) && tick;
  assign done = (state_reg == st_convert) && tick && approx_last &&
                run_now && !chan_wr;
  assign load = done && !cfg_wr;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_reg <= st_idle;
    else
      state_reg <= state_next;
  end

  // sampling period counted inside the conversion time
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      sample_cnt_reg <= 2'h0;
    else if ((state_reg != st_sample) || start_conv)
      sample_cnt_reg <= 2'h0;
    else if (tick)
      sample_cnt_reg <= sample_cnt_reg + 2'h1;
  end

  sadc_trial_timer u_timer
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_restart(start_conv),
    .i_period(trial_period),
    .o_tick(tick)
  );

  sadc_approx_search u_search
  (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_start(approx_start),
    .i_step(approx_step),
    .i_comp_ge(i_comp_ge),
    .o_code(approx_code),
    .o_decided(approx_decided),
    .o_last(approx_last)
  );

  // results and completion pulse
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      result_word_reg <= `SADC_RESULT_RESET;
      result_high_byte_reg <= `SADC_RESULT_HI_RESET;
      o_conversion_done_irq <= 1'b0;
    end
    else
    begin
      o_conversion_done_irq <= load;
      if (load)
      begin
        result_word_reg <= {approx_decided, `SADC_RESULT_PAD};
        result_high_byte_reg <= approx_decided[9:2];
      end
    end
  end

  // analog side outputs
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_comparator_enable <= 1'b0;
      o_sampling <= 1'b0;
      o_hold <= 1'b0;
      o_channel <= `SADC_CHAN_RESET;
      o_pin_analog_config <= `SADC_PIN_RESET;
    end
    else
    begin
      o_comparator_enable <= mode_wr ? w_data_reg[`SADC_MODE_ENABLE_BIT]
        : converter_mode_reg[`SADC_MODE_ENABLE_BIT];
      o_sampling <= (state_next == st_sample);
      o_hold <= (state_next == st_convert);
      o_channel <= chan_wr ? w_data_reg[`SADC_CHAN_MSB:0]
                           : channel_select_reg;
      o_pin_analog_config <= pin_wr ? w_data_reg[`SADC_PIN_MSB:0]
                                    : pin_analog_cfg_reg;
    end
  end
  assign o_tap_code = approx_code;

  a_irq_one_clock: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_conversion_done_irq |=> !o_conversion_done_irq)
    else $error("done pulse longer than one clock");
  a_irq_with_load: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    load |=> o_conversion_done_irq &&
    result_word_reg[15:6] == $past(approx_decided))
    else $error("result not latched with done pulse");
  a_word_left_just: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    result_word_reg[5:0] == 6'h00 &&
    result_word_reg[15:8] == result_high_byte_reg)
    else $error("result word and high byte disagree");
  a_run_clear_halt: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    mode_wr && !w_data_reg[7] |=> state_reg == st_idle && !o_hold
    ##1 $stable(result_word_reg))
    else $error("conversion not halted by run clear");
  a_chan_restart: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    chan_wr && run_now |=> state_reg == st_sample && o_sampling
    && !o_conversion_done_irq)
    else $error("channel write did not restart");
  a_first_trial_half: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    approx_start |=> o_tap_code == 10'h200 && o_hold)
    else $error("first trial not at half tap");
  a_second_trial_tap: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    approx_step && o_tap_code == 10'h200 |=>
    o_tap_code[8] && o_tap_code[9] == $past(i_comp_ge))
    else $error("second trial tap wrong");
  a_cfg_write_wins: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    done && cfg_wr |=> !o_conversion_done_irq &&
    $stable(result_word_reg))
    else $error("completion not suppressed by config write");
  a_enable_follows: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    mode_wr |=> o_comparator_enable == $past(w_data_reg[0]))
    else $error("comparator enable does not follow mode");
  a_sample_then_hold: assert property (@(posedge i_clock)
    disable iff (i_sys_rst)
    $rose(o_hold) |-> $past(o_sampling, 2) && tick == 1'b0)
    else $error("hold not preceded by sampling");
endmodule

// *** tb/sadc_analog_model.sv ***
// analog side model: sample-and-hold feeding a comparator against the tap
// assumes the bench drives i_level steady across each sampling period
`timescale 1ns/100ps
module sadc_analog_model
(
  // clock
  input wire logic i_clock,
  // analog input and converter controls
  input wire logic [9:0] i_level,
  input wire logic i_sampling,
  input wire logic i_hold,
  input wire logic [9:0] i_tap_code,
  // comparator
  output logic o_comp_ge
);
  logic [9:0] held_reg;
  logic junk_reg;

  initial
  begin
    held_reg = 10'h000;
    junk_reg = 1'b0;
  end

  // capacitor tracks the input only while the switch is on
  always @(posedge i_clock)
  begin
    if (i_sampling)
      held_reg <= i_level;
    junk_reg <= ~junk_reg;
  end

  // outside hold the comparator output is meaningless, so it toggles
  assign o_comp_ge = i_hold ? (held_reg >= i_tap_code) : junk_reg;
endmodule

// *** tb/tb.sv ***
// self-checking bench of the converter sequencer and its analog model
// assumes the map offsets and a 12 trial period conversion
`timescale 1ns/100ps
`include "sadc_map.svh"
module tb;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, comp_ge, en, smp, hold, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, pincfg;
  logic [1:0] bresp, rresp, r;
  logic [2:0] chan;
  logic [9:0] tap, level;
  logic [15:0] rnd;
  logic armed, hold_q, irq_q;
  int failures, checks_done, cyc, t_start, t_hold, t_irq, t_prev, irq_n;
  int p_cur, code, n, tv;

  sadc_top u_sadc_top
  (
    .i_clock(clk), .i_sys_rst(rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_comp_ge(comp_ge),
    .o_comparator_enable(en), .o_sampling(smp), .o_hold(hold),
    .o_channel(chan), .o_tap_code(tap), .o_pin_analog_config(pincfg),
    .o_conversion_done_irq(irq)
  );

  sadc_analog_model u_sadc_analog_model
  (
    .i_clock(clk), .i_level(level), .i_sampling(smp), .i_hold(hold),
    .i_tap_code(tap), .o_comp_ge(comp_ge)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // search done the slow way: keep each trial bit when input >= tap
  function automatic int model_code(input int lvl);
    int c;
    c = 0;
    for (int b = 9; b >= 0; b--)
      if (lvl >= (c | (1 << b)))
        c = c | (1 << b);
    return c;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    while (bvalid !== 1'b1)
      @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_irq();
    n = irq_n;
    while (irq_n == n)
      @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // timing monitor, looks once the edge's updates have landed
  always @(posedge clk)
  begin
    #1;
    cyc++;
    if (armed && smp === 1'b1)
    begin
      t_start = cyc;
      armed = 1'b0;
    end
    if (hold === 1'b1 && hold_q !== 1'b1)
    begin
      t_hold = cyc;
      chk(32'(tap), 32'h200);
    end
    if (hold === 1'b1 && cyc == t_hold + p_cur)
      chk(32'(tap), {22'h0, level[9], 9'h100});
    if (irq === 1'b1)
    begin
      chk(32'(irq_q), 32'h0);
      t_prev = t_irq;
      t_irq = cyc;
      irq_n++;
    end
    hold_q = hold;
    irq_q = irq;
  end

  initial
  begin
    #(40 * 80000);
    failures++;
    results();
  end

  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready, armed} = 7'h41;
    {awaddr, araddr, wdata, level} = '0;
    wstrb = 4'hf;
    rnd = 16'h0043;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`SADC_OFF_RESULT);
    chk(d, 32'h0);
    rd(`SADC_OFF_RESULT_HI);
    chk(d, 32'h0);
    rd(8'h18);
    chk(32'(r), 32'(`SADC_RESP_SLVERR));
    wr(8'h18, 32'h0);
    chk(32'(r), 32'(`SADC_RESP_SLVERR));
    wr(`SADC_OFF_CHAN, 32'hff);
    rd(`SADC_OFF_CHAN);
    chk(d, 32'h7);
    wr(`SADC_OFF_PIN, 32'h5);
    chk(32'(pincfg), 32'h5);
    wr(`SADC_OFF_MODE, 32'h1);
    chk(32'(en), 32'h1);
    repeat (25) @(posedge clk);
    for (int ch = 0; ch < 8; ch++)
    begin
      rnd = lfsr(rnd);
      tv = (ch == 0) ? 31 : int'(rnd[14:10]);
      p_cur = tv + 2;
      level <= (ch == 7) ? 10'h3ff : rnd[9:0];
      code = model_code((ch == 7) ? 1023 : int'(rnd[9:0]));
      wr(`SADC_OFF_CHAN, 32'(ch));
      chk(32'(chan), 32'(ch));
      armed = 1'b1;
      wr(`SADC_OFF_MODE, 32'h81 | 32'(tv << 1));
      wait_irq();
      chk(32'(t_irq - t_start), 32'(12 * p_cur));
      chk(32'(t_irq - t_hold), 32'(10 * p_cur));
      rd(`SADC_OFF_RESULT);
      chk(d, 32'(code << 6));
      rd(`SADC_OFF_RESULT_HI);
      chk(d, 32'(code >> 2));
      wait_irq();
      chk(32'(t_irq - t_prev), 32'(12 * p_cur));
      while (hold !== 1'b1)
        @(posedge clk);
      n = irq_n;
      wr(`SADC_OFF_MODE, 32'h1);
      chk(32'({smp, hold}), 32'h0);
      repeat (12 * p_cur + 4) @(posedge clk);
      chk(32'(irq_n - n), 32'h0);
      rd(`SADC_OFF_RESULT);
      chk(d, 32'(code << 6));
    end
    // run with the comparator off, drop the first result, then restart
    wr(`SADC_OFF_MODE, 32'h0);
    wr(`SADC_OFF_CHAN, 32'h0);
    level <= 10'h155;
    p_cur = 33;
    wr(`SADC_OFF_MODE, 32'hbe);
    chk(32'(en), 32'h0);
    wait_irq();
    while (hold !== 1'b1)
      @(posedge clk);
    level <= 10'h2aa;
    armed = 1'b1;
    wr(`SADC_OFF_CHAN, 32'h5);
    wait_irq();
    chk(32'(t_irq - t_start), 32'(12 * p_cur));
    rd(`SADC_OFF_RESULT);
    chk(d, 32'(model_code(682) << 6));
    results();
  end
endmodule
